// ---- src/uitc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - HS extra clocks times bit factor added to HS base timeout.
// - HS base timeout lies within 736 to 816 bit times.
// - Each HS extra clock adds eight bit times.
// - FS extra clocks times bit factor added to FS base timeout.
// - FS base timeout lies within 16 to 18 bit times.
// - Each FS extra clock adds two tenths of a bit time.
// - Only the 60 MHz transceiver factors are used.
// - Scale 00 keeps all timers at full length.
// - Scale 01 shortens all but suspend and resume.
// - Scale 10 shortens only suspend and resume.
// - Scale 11 shortens both groups.
// - Scale field is read/write and resets to 00.
// - Calibration fields default to EEPROM image, else OTP, else zero.
// - USB or lite reset reloads calibration fields from last image; scale keeps its value.
module uitc_top
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire uitc_pkg::uitc_apb_req_t apb_req,
  output uitc_pkg::uitc_apb_rsp_t apb_rsp,
  input wire logic image_done,
  input wire logic eeprom_present,
  input wire uitc_pkg::uitc_image_t eeprom_image,
  input wire logic otp_present,
  input wire uitc_pkg::uitc_image_t otp_image,
  input wire logic usb_reset,
  input wire logic lite_reset_request,
  output logic [9:0] hs_timeout_bits,
  output logic [7:0] fs_timeout_tenths,
  output logic scale_other_timers,
  output logic scale_suspend_resume,
  output logic cfg_ready
);
  import uitc_pkg::*;

  // -------------------------------------------------
  // Declarations
  // -------------------------------------------------
  uitc_state_t state_ff;
  uitc_state_t nxt_state;
  uitc_image_t img_ff;
  uitc_apb_rsp_t rsp_ff;
  logic [2:0] hs_cal_ff;
  logic [2:0] fs_cal_ff;
  logic [1:0] scale_ff;
  logic [9:0] hs_tout_ff;
  logic [7:0] fs_tout_ff;
  logic sc_other_ff;
  logic sc_susp_ff;
  logic ready_ff;
  logic setup;
  logic hit;
  logic wr_en;
  logic reload;

  // Register decode, used by read and write paths
  function automatic logic addr_hit(input logic [11:0] a);
    if (a == TIMING_CFG_OFS)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  // Image selection by source priority
  function automatic uitc_image_t pick_image(
    input logic ee_p,
    input uitc_image_t ee,
    input logic otp_p,
    input uitc_image_t otp
  );
    if (ee_p)
      return ee;
    else if (otp_p)
      return otp;
    else
      return '0;
  endfunction

  // -------------------------------------------------
  // Bus strobes
  // -------------------------------------------------
  assign setup = apb_req.psel & ~apb_req.penable;
  assign hit = addr_hit(apb_req.paddr);
  assign wr_en = apb_req.psel & apb_req.penable & rsp_ff.pready
    & apb_req.pwrite & hit;
  assign reload = usb_reset | lite_reset_request;

  // -------------------------------------------------
  // Loader state machine
  // -------------------------------------------------
  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT:
      begin
        if (image_done)
          nxt_state = ST_LOAD;
      end
      ST_LOAD:
        nxt_state = ST_RUN;
      ST_RUN:
        nxt_state = ST_RUN;
      default:
        nxt_state = ST_WAIT;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_ff <= ST_WAIT;
    else
      state_ff <= nxt_state;
  end

  // Ready flag, flopped so the pin comes from a register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ready_ff <= 1'b0;
    else
      ready_ff <= (nxt_state == ST_RUN);
  end

  // Captured image, kept for later reloads
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      img_ff <= '0;
    else if (state_ff == ST_WAIT && image_done)
      img_ff <= pick_image(eeprom_present, eeprom_image,
        otp_present, otp_image);
  end

  // -------------------------------------------------
  // Configuration fields
  // -------------------------------------------------
  // Calibration counts: load, reload, then software
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_cal_ff <= CAL_RST;
      fs_cal_ff <= CAL_RST;
    end
    else if (state_ff == ST_LOAD || reload)
    begin
      hs_cal_ff <= img_ff.hs_timeout_extra_clocks_image;
      fs_cal_ff <= img_ff.fs_timeout_extra_clocks_image;
    end
    else if (wr_en)
    begin
      hs_cal_ff <= apb_req.pwdata[HS_CAL_LSB +: 3];
      fs_cal_ff <= apb_req.pwdata[FS_CAL_LSB +: 3];
    end
  end

  // Scale-down select, plain read/write
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      scale_ff <= SCALE_RST;
    else if (wr_en)
      scale_ff <= apb_req.pwdata[SCALE_LSB +: 2];
  end

  // -------------------------------------------------
  // Timeout computation
  // -------------------------------------------------
  // Base plus count times the 60 MHz factor
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_tout_ff <= HS_BASE_BITS;
      fs_tout_ff <= FS_BASE_TENTHS;
    end
    else
    begin
      hs_tout_ff <= HS_BASE_BITS + 10'({7'h0, hs_cal_ff} * HS_BITS_PER_CLK);
      fs_tout_ff <= FS_BASE_TENTHS + 8'({5'h0, fs_cal_ff} * FS_TENTHS_PER_CLK);
    end
  end

  // Scale-down enables per timer group
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sc_other_ff <= 1'b0;
      sc_susp_ff <= 1'b0;
    end
    else
    begin
      sc_other_ff <= scale_ff[0];
      sc_susp_ff <= scale_ff[1];
    end
  end

  // -------------------------------------------------
  // APB slave answer
  // -------------------------------------------------
  // One wait-free access cycle; unmapped gives error
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rsp_ff <= '0;
    else if (setup)
    begin
      rsp_ff.pready <= 1'b1;
      rsp_ff.pslverr <= ~hit;
      rsp_ff.prdata <= '0;
      if (hit && !apb_req.pwrite)
      begin
        rsp_ff.prdata[HS_CAL_LSB +: 3] <= hs_cal_ff;
        rsp_ff.prdata[FS_CAL_LSB +: 3] <= fs_cal_ff;
        rsp_ff.prdata[SCALE_LSB +: 2] <= scale_ff;
      end
    end
    else
      rsp_ff <= '0;
  end

  // Outputs straight from flops
  assign apb_rsp = rsp_ff;
  assign hs_timeout_bits = hs_tout_ff;
  assign fs_timeout_tenths = fs_tout_ff;
  assign scale_other_timers = sc_other_ff;
  assign scale_suspend_resume = sc_susp_ff;
  assign cfg_ready = ready_ff;

  // -------------------------------------------------
  // Assertions
  // -------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_hs_calc;
    1 |=> hs_tout_ff == 10'(HS_BASE_BITS + {$past(hs_cal_ff), 3'b000});
  endproperty
  a_hs_calc: assert property (p_hs_calc)
    else $error("HS timeout not base plus eight per clock");

  property p_hs_win;
    1 |=> hs_tout_ff - {4'h0, $past(hs_cal_ff), 3'h0} >= 10'(HS_WIN_MIN) &&
      hs_tout_ff - {4'h0, $past(hs_cal_ff), 3'h0} <= 10'(HS_WIN_MAX);
  endproperty
  a_hs_win: assert property (p_hs_win)
    else $error("HS base outside window");

  property p_fs_calc;
    1 |=> fs_tout_ff == 8'(FS_BASE_TENTHS + {$past(fs_cal_ff), 1'b0});
  endproperty
  a_fs_calc: assert property (p_fs_calc)
    else $error("FS timeout not base plus two tenths per clock");

  property p_fs_win;
    ##1 (fs_tout_ff - {4'h0, $past(fs_cal_ff), 1'b0}) >= 8'(FS_WIN_MIN_T) &&
      (fs_tout_ff - {4'h0, $past(fs_cal_ff), 1'b0}) <= 8'(FS_WIN_MAX_T);
  endproperty
  a_fs_win: assert property (p_fs_win)
    else $error("FS base outside window");

  property p_scale_off;
    scale_ff == 2'h0 |=> !sc_other_ff && !sc_susp_ff;
  endproperty
  a_scale_off: assert property (p_scale_off)
    else $error("Scaling active with field at zero");

  property p_scale_grp;
    1 |=> sc_other_ff == $past(scale_ff[0]) && sc_susp_ff == $past(scale_ff[1]);
  endproperty
  a_scale_grp: assert property (p_scale_grp)
    else $error("Scale group enables do not follow field");

  property p_scale_rw;
    wr_en |=> scale_ff == $past(apb_req.pwdata[SCALE_LSB +: 2]);
  endproperty
  a_scale_rw: assert property (p_scale_rw)
    else $error("Scale field not taken from write");

  property p_rd_back;
    setup && hit && !apb_req.pwrite |=> rsp_ff.pready && !rsp_ff.pslverr &&
      rsp_ff.prdata == {16'h0, $past(hs_cal_ff), 6'h0, $past(fs_cal_ff), 2'h0,
      $past(scale_ff)};
  endproperty
  a_rd_back: assert property (p_rd_back)
    else $error("Register read back differs from fields");

  property p_load;
    state_ff == ST_LOAD || reload |=>
      hs_cal_ff == $past(img_ff.hs_timeout_extra_clocks_image) &&
      fs_cal_ff == $past(img_ff.fs_timeout_extra_clocks_image);
  endproperty
  a_load: assert property (p_load)
    else $error("Calibration not taken from image");

  property p_pick;
    state_ff == ST_WAIT && image_done && !eeprom_present && !otp_present
      |=> img_ff == '0;
  endproperty
  a_pick: assert property (p_pick)
    else $error("Missing image did not give zero");
endmodule // uitc_top

// ---- src/uitc_pkg.sv ----
package uitc_pkg;
  // -------------------------------------------------
  // Register map
  // -------------------------------------------------
  localparam logic [11:0] TIMING_CFG_OFS = 12'h084;
  localparam int HS_CAL_LSB = 13;
  localparam int FS_CAL_LSB = 4;
  localparam int SCALE_LSB = 0;
  localparam logic [2:0] CAL_RST = 3'h0;
  localparam logic [1:0] SCALE_RST = 2'h0;
  // -------------------------------------------------
  // Timing figures, in bit times
  // -------------------------------------------------
  localparam int PHY_CLK_MHZ = 60;
  localparam int HS_WIN_MIN = 736;
  localparam int HS_WIN_MAX = 816;
  localparam logic [9:0] HS_BASE_BITS = 10'h2e0;
  localparam logic [9:0] HS_BITS_PER_CLK = 10'h008;
  // Full speed in tenths of a bit time
  localparam int FS_WIN_MIN_T = 160;
  localparam int FS_WIN_MAX_T = 180;
  localparam logic [7:0] FS_BASE_TENTHS = 8'ha0;
  localparam logic [7:0] FS_TENTHS_PER_CLK = 8'h02;
  // -------------------------------------------------
  // Types
  // -------------------------------------------------
  typedef struct packed {
    logic [2:0] hs_timeout_extra_clocks_image;
    logic [2:0] fs_timeout_extra_clocks_image;
  } uitc_image_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uitc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uitc_apb_rsp_t;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11
  } uitc_state_t;
endpackage

// ---- bench/uitc_img_src.sv ----
`timescale 1ns/1ps
// ----------------------------
// Config image source model
// ----------------------------
module uitc_img_src
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [1:0] src,
  input wire uitc_pkg::uitc_image_t img,
  output logic image_done,
  output logic eeprom_present,
  output uitc_pkg::uitc_image_t eeprom_image,
  output logic otp_present,
  output uitc_pkg::uitc_image_t otp_image
);
  import uitc_pkg::*;
  // Valid only with the done pulse, scrambled otherwise
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      image_done <= 1'b0;
      eeprom_present <= 1'b0;
      otp_present <= 1'b0;
      eeprom_image <= '0;
      otp_image <= '0;
    end
    else
    begin
      image_done <= go;
      eeprom_present <= go ? src[1] : ~eeprom_present;
      otp_present <= go ? src[0] : ~otp_present;
      eeprom_image <= go ? img : ~eeprom_image;
      otp_image <= go ? ~img : ~otp_image; // Differs from eeprom copy
    end
  end
endmodule // uitc_img_src

// ---- bench/tb.sv ----
`timescale 1ns/1ps
// ----------------------------
// Testbench
// ----------------------------
module tb;
  import uitc_pkg::*;
  logic sys_clk, resetn, go, usb_reset, lite_reset_request, image_done;
  logic ee_p, otp_p, scl_o, scl_s, cfg_ready, serr;
  logic [1:0] src;
  logic [9:0] hs_t;
  logic [7:0] fs_t;
  logic [31:0] rd, d;
  uitc_image_t img, ee_i, otp_i;
  uitc_apb_req_t req;
  uitc_apb_rsp_t rsp;
  int err_count, samples_checked, hs, fs, sc, ihs, ifs;

  uitc_top uut(.sys_clk(sys_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .image_done(image_done), .eeprom_present(ee_p), .eeprom_image(ee_i),
    .otp_present(otp_p), .otp_image(otp_i), .usb_reset(usb_reset),
    .lite_reset_request(lite_reset_request), .hs_timeout_bits(hs_t),
    .fs_timeout_tenths(fs_t), .scale_other_timers(scl_o),
    .scale_suspend_resume(scl_s), .cfg_ready(cfg_ready));
  uitc_img_src part(.sys_clk(sys_clk), .resetn(resetn), .go(go), .src(src), .img(img),
    .image_done(image_done), .eeprom_present(ee_p), .eeprom_image(ee_i),
    .otp_present(otp_p), .otp_image(otp_i));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    serr = rsp.pslverr;
    req <= '0;
  endtask

  // Model register image
  function automatic logic [31:0] ev();
    return {16'h0, hs[2:0], 6'h0, fs[2:0], 2'h0, sc[1:0]};
  endfunction

  task automatic look;
    repeat (2) @(negedge sys_clk);
    chk(hs_t, 736 + 8 * hs);
    chk(fs_t, 160 + 2 * fs);
    chk(scl_o, sc[0]);
    chk(scl_s, sc[1]);
    apb(1'b0, TIMING_CFG_OFS, 32'h0);
    chk(rd, ev());
    chk(serr, 1'b0);
  endtask

  task automatic rst;
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    hs = 0;
    fs = 0;
    sc = 0;
  endtask

  task automatic load(input logic [1:0] s);
    int n;
    n = 0;
    rst;
    @(posedge sys_clk);
    src <= s;
    img <= uitc_image_t'($urandom);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    while (cfg_ready !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(cfg_ready, 1'b1);
    chk(n, 32'd3);
    ihs = s[1] ? img[5:3] : s[0] ? img[5:3] ^ 3'h7 : 0;
    ifs = s[1] ? img[2:0] : s[0] ? img[2:0] ^ 3'h7 : 0;
    hs = ihs;
    fs = ifs;
    look;
  endtask

  task automatic wr_rand(input logic [1:0] s);
    d = $urandom;
    d[1:0] = s;
    apb(1'b1, TIMING_CFG_OFS, d);
    hs = d[15:13];
    fs = d[6:4];
    sc = s;
    look;
  endtask

  task automatic reload(input logic lite);
    wr_rand(2'h3);
    @(posedge sys_clk);
    if (lite)
      lite_reset_request <= 1'b1;
    else
      usb_reset <= 1'b1;
    @(posedge sys_clk);
    lite_reset_request <= 1'b0;
    usb_reset <= 1'b0;
    hs = ihs;
    fs = ifs;
    look;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #300000;
    err_count++;
    print_verdict;
  end

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    req = '0;
    go = 1'b0;
    src = 2'h0;
    img = '0;
    usb_reset = 1'b0;
    lite_reset_request = 1'b0;
    void'($urandom(15));
    rst;
    look;
    $display("reset defaults done");
    for (int i = 0; i < 4; i++)
      load(i[1:0]);
    $display("image load done");
    for (int i = 0; i < 8; i++)
      wr_rand(i[1:0]);
    $display("register writes done");
    reload(1'b0);
    reload(1'b1);
    $display("reloads done");
    apb(1'b1, 12'h088, 32'hffffffff);
    chk(serr, 1'b1);
    apb(1'b0, 12'h088, 32'h0);
    chk(serr, 1'b1);
    chk(rd, 32'h0);
    look;
    sc = 0;
    apb(1'b1, TIMING_CFG_OFS, ev());
    look;
    $display("unmapped and cleanup done");
    print_verdict;
  end
endmodule // tb
